/* common/arc_pkg.sv */
`default_nettype none
package arc_pkg;

    // clock of the register logic
    localparam int unsigned CLK_HZ_DEFAULT = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 25;

    // register pointer codes
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_LO_THRESH = 2'h2;
    localparam logic [1:0] PTR_HI_THRESH = 2'h3;

    // reset values
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h8583;
    localparam logic [15:0] UNKEPT_READ = 16'h0000;

    // result layout: code in 15:4, pad in 3:0
    localparam int unsigned RESULT_CODE_W = 12;
    localparam logic [3:0] RESULT_PAD = 4'h0;

    // configuration field codes
    localparam logic [1:0] QUEUE_OFF = 2'h3;
    localparam logic MODE_SINGLE = 1'b1;
    localparam logic POL_HIGH = 1'b1;

    // configuration bits 14:0, bit 15 is the start/status bit
    typedef struct packed {
        logic [2:0] input_select;
        logic [2:0] gain_range;
        logic single_mode;
        logic [2:0] sample_rate;
        logic comparator_kind;
        logic comparator_polarity;
        logic comparator_latching;
        logic [1:0] comparator_queue;
    } arc_cfg_t;

    // sample rate table, samples per second, indexed by sample_rate
    localparam int unsigned RATE_SPS [0:7] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};

    // serial link constants
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_TX_LAST = 4'h7;
    localparam logic [1:0] BYTE_PTR = 2'h0;
    localparam logic [1:0] BYTE_HI = 2'h1;
    localparam logic [1:0] BYTE_LO = 2'h2;

    // serial slave states, gray along the write path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK = 3'h3,
        ST_RX = 3'h2,
        ST_TX = 3'h6,
        ST_TXACK = 3'h7
    } arc_state_t;

endpackage
`default_nettype wire

/* core/arc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two flop synchroniser for pin levels
module arc_sync #(
    parameter int unsigned WIDTH = 2,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import arc_pkg::*;

    // first stage is only read by the second
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } arc_sync_state_t;

    arc_sync_state_t q_r;
    arc_sync_state_t q_nxt;

    // next state
    always_comb begin
        q_nxt.meta = async_in;
        q_nxt.stable = q_r.meta;
    end

    // idle level at reset so no false start is seen
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q_r <= {IDLE_LEVEL, IDLE_LEVEL};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sync_out = q_r.stable;

endmodule
`default_nettype wire

/* core/arc_conv_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// paces conversions at the selected sample rate
module arc_conv_timer #(
    parameter int unsigned CLK_HZ = arc_pkg::CLK_HZ_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // control
    input wire logic start,
    input wire logic single_mode,
    input wire logic [2:0] sample_rate,
    // status
    output logic busy,
    output logic done
);
    import arc_pkg::*;

    localparam int unsigned CNT_W = $clog2(CLK_HZ / RATE_SPS[0] + 1);

    // a rate the clock cannot reach would give a zero period
    if (CLK_HZ < RATE_SPS[6]) begin : g_bad_clk
        $error("clock slower than fastest sample rate");
    end

    typedef struct packed {
        logic busy;
        logic done;
        logic [CNT_W-1:0] cnt;
    } arc_tmr_state_t;

    arc_tmr_state_t q_r;
    arc_tmr_state_t q_nxt;

    // RULE_11: period from rate table
    // cycles of one conversion, rounded down, at least one
    function automatic logic [CNT_W-1:0] period_m1(input logic [2:0] rate);
        int unsigned cyc;
        cyc = CLK_HZ / RATE_SPS[rate];
        if (cyc < 1) begin
            cyc = 1;
        end
        return CNT_W'(cyc - 1);
    endfunction

    // RULE_10: continuous chains, single stops
    // continuous mode chains conversions back to back
    always_comb begin
        q_nxt = q_r;
        q_nxt.done = 1'b0;
        if (!q_r.busy) begin
            if (start || single_mode != MODE_SINGLE) begin
                q_nxt.busy = 1'b1;
                q_nxt.cnt = period_m1(sample_rate);
            end
        end else if (q_r.cnt == '0) begin
            q_nxt.done = 1'b1;
            q_nxt.busy = (single_mode != MODE_SINGLE);
            q_nxt.cnt = period_m1(sample_rate);
        end else begin
            q_nxt.cnt = q_r.cnt - 1'b1;
        end
    end

    // powered down after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign busy = q_r.busy;
    assign done = q_r.done;

endmodule
`default_nettype wire

/* core/arc_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01: result register holds latest two's complement code
// RULE_02: result reads zero until first conversion
// RULE_03: code in 15:4, bits 3:0 zero
// RULE_04: configuration resets to 8583h
// RULE_05: writing start bit one begins conversion
// RULE_06: start write ignored while converting
// RULE_07: start bit reads zero while converting
// RULE_08: input_select chooses the input pair
// RULE_09: gain_range sets full-scale range
// RULE_10: mode zero continuous, one single-shot
// RULE_11: sample_rate sets conversion rate
// RULE_12: two-bit pointer selects the register
// RULE_13: queue 11 disables comparator, alert released
// RULE_14: polarity and comparator kind bits
// RULE_15: result updated in one step
// RULE_16: writes to result register ignored
module arc_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary slave address
    parameter int unsigned CLK_HZ = arc_pkg::CLK_HZ_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // serial pins, open drain data
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_drive_b,
    // converter side, same clock
    input wire logic [11:0] adc_code,
    output arc_pkg::arc_cfg_t cfg_out,
    output logic conv_active,
    output logic conv_done,
    // alert pin, open drain
    output logic alert_out,
    output logic alert_drive_b
);
    import arc_pkg::*;

    // all state of the slave and register file
    typedef struct packed {
        arc_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [1:0] ptr;
        logic [1:0] byte_idx;
        logic [7:0] wr_hi;
        logic [15:0] snap;
        logic tx_lo;
        logic acked;
        logic drive_b;
        logic prev_scl;
        logic prev_sda;
        logic start;
        arc_cfg_t cfg;
        logic [15:0] result;
        logic alert_drive_b;
    } arc_regs_state_t;

    localparam arc_regs_state_t RESET_STATE = '{
        st: ST_IDLE,
        cnt: 4'h0,
        sh: 8'h00,
        rw: 1'b0,
        ptr: PTR_RESULT,
        byte_idx: BYTE_PTR,
        wr_hi: 8'h00,
        snap: 16'h0000,
        tx_lo: 1'b0,
        acked: 1'b0,
        drive_b: 1'b1,
        prev_scl: 1'b1,
        prev_sda: 1'b1,
        start: 1'b0,
        cfg: arc_cfg_t'(CONFIG_RESET[14:0]),
        result: RESULT_RESET,
        alert_drive_b: 1'b1
    };

    arc_regs_state_t q_r;
    arc_regs_state_t q_nxt;

    logic [1:0] pins_sync; // scl in bit 1, sda in bit 0
    logic scl; // synchronised clock line
    logic sda; // synchronised data line
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic busy_now; // conversion running or just requested

    // pins cross into the clock domain first
    arc_sync #(
        .WIDTH(2),
        .IDLE_LEVEL(2'h3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({scl_pin, sda_pin_in}),
        .sync_out(pins_sync)
    );

    // conversion pacing
    arc_conv_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(q_r.start),
        .single_mode(q_r.cfg.single_mode),
        .sample_rate(q_r.cfg.sample_rate),
        .busy(conv_active),
        .done(conv_done)
    );

    // edges and bus conditions from synchronised levels
    always_comb begin
        scl = pins_sync[1];
        sda = pins_sync[0];
        scl_rise = scl && !q_r.prev_scl;
        scl_fall = !scl && q_r.prev_scl;
        start_cond = scl && q_r.prev_scl && q_r.prev_sda && !sda;
        stop_cond = scl && q_r.prev_scl && !q_r.prev_sda && sda;
        busy_now = conv_active || q_r.start;
    end

    // read mux, threshold registers are not kept here
    function automatic logic [15:0] rd_word(input logic [1:0] ptr,
                                            input logic [15:0] result,
                                            input arc_cfg_t cfg,
                                            input logic busy);
        case (ptr)
            PTR_RESULT: rd_word = result;
            // RULE_07: status reads busy inverted
            PTR_CONFIG: rd_word = {!busy, cfg};
            default: rd_word = UNKEPT_READ;
        endcase
    endfunction

    // slave sequencing, register writes and result capture
    always_comb begin
        logic [15:0] word;
        logic [7:0] tx_byte;
        arc_cfg_t new_cfg;
        word = rd_word(q_r.ptr, q_r.result, q_r.cfg, busy_now);
        tx_byte = 8'h00;
        new_cfg = arc_cfg_t'({q_r.wr_hi[6:0], q_r.sh});
        q_nxt = q_r;
        q_nxt.start = 1'b0;
        q_nxt.prev_scl = scl;
        q_nxt.prev_sda = sda;
        if (start_cond) begin
            // a start, repeated or not, restarts address reception
            q_nxt.st = ST_ADDR;
            q_nxt.cnt = 4'h0;
            q_nxt.drive_b = 1'b1;
        end else if (stop_cond) begin
            q_nxt.st = ST_IDLE;
            q_nxt.drive_b = 1'b1;
        end else begin
            case (q_r.st)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        // sample data while the clock is high
                        q_nxt.sh = {q_r.sh[6:0], sda};
                        q_nxt.cnt = q_r.cnt + 4'h1;
                    end else if (scl_fall && q_r.cnt == BIT_LAST) begin
                        q_nxt.cnt = 4'h0;
                        q_nxt.st = ST_ACK;
                        q_nxt.drive_b = 1'b0;
                        if (q_r.st == ST_ADDR) begin
                            if (q_r.sh[7:1] == DEV_ADDR) begin
                                q_nxt.rw = q_r.sh[0];
                                q_nxt.byte_idx = BYTE_PTR;
                                q_nxt.tx_lo = 1'b0;
                                // RULE_15: whole word snapshot
                                q_nxt.snap = word;
                            end else begin
                                // not ours, keep off the line
                                q_nxt.st = ST_IDLE;
                                q_nxt.drive_b = 1'b1;
                            end
                        end else begin
                            case (q_r.byte_idx)
                                BYTE_PTR: begin
                                    // RULE_12: pointer byte selects register
                                    q_nxt.ptr = q_r.sh[1:0];
                                    q_nxt.byte_idx = BYTE_HI;
                                end
                                BYTE_HI: begin
                                    q_nxt.wr_hi = q_r.sh;
                                    q_nxt.byte_idx = BYTE_LO;
                                end
                                default: begin
                                    // both bytes in, commit together
                                    q_nxt.byte_idx = BYTE_HI;
                                    if (q_r.ptr == PTR_CONFIG) begin
                                        // RULE_08: fields stored as written
                                        // RULE_09: range field stored
                                        // RULE_11: rate field stored
                                        q_nxt.cfg = new_cfg;
                                        // RULE_05: one starts a conversion
                                        // RULE_06: not while converting
                                        if (q_r.wr_hi[7] && !busy_now &&
                                            new_cfg.single_mode == MODE_SINGLE) begin
                                            q_nxt.start = 1'b1;
                                        end
                                    end
                                    // RULE_16: result pointer writes dropped
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        q_nxt.cnt = 4'h0;
                        if (q_r.rw) begin
                            // drive first bit of the high byte
                            tx_byte = q_r.snap[15:8];
                            q_nxt.sh = tx_byte;
                            q_nxt.drive_b = tx_byte[7];
                            q_nxt.st = ST_TX;
                        end else begin
                            q_nxt.drive_b = 1'b1;
                            q_nxt.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (q_r.cnt == BIT_TX_LAST) begin
                            // release for the master's acknowledge
                            q_nxt.drive_b = 1'b1;
                            q_nxt.cnt = 4'h0;
                            q_nxt.st = ST_TXACK;
                        end else begin
                            q_nxt.sh = {q_r.sh[6:0], 1'b0};
                            q_nxt.drive_b = q_r.sh[6];
                            q_nxt.cnt = q_r.cnt + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        q_nxt.acked = !sda;
                    end else if (scl_fall) begin
                        if (q_r.acked) begin
                            // after the low byte take a fresh snapshot
                            q_nxt.tx_lo = !q_r.tx_lo;
                            if (q_r.tx_lo) begin
                                q_nxt.snap = word;
                                tx_byte = word[15:8];
                            end else begin
                                tx_byte = q_r.snap[7:0];
                            end
                            q_nxt.sh = tx_byte;
                            q_nxt.drive_b = tx_byte[7];
                            q_nxt.st = ST_TX;
                        end else begin
                            // no acknowledge ends the read
                            q_nxt.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    q_nxt.drive_b = 1'b1;
                end
            endcase
        end
        // RULE_01: capture latest code
        // RULE_03: low nibble padded with zero
        if (conv_done) begin
            q_nxt.result = {adc_code, RESULT_PAD};
        end
        // RULE_13: queue off releases alert
        // RULE_14: active high idles driven low
        q_nxt.alert_drive_b = (q_nxt.cfg.comparator_queue == QUEUE_OFF) ||
                              (q_nxt.cfg.comparator_polarity != POL_HIGH);
    end

    // RULE_04: reset loads configuration default
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q_r <= RESET_STATE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // drive enables and cfg_out straight from state flops, sda_pin_out and alert_out tied low
    assign sda_pin_out = 1'b0;
    assign sda_drive_b = q_r.drive_b;
    // RULE_10: mode bit goes to the timer and out
    assign cfg_out = q_r.cfg;
    assign alert_out = 1'b0;
    assign alert_drive_b = q_r.alert_drive_b;

    // RULE_02: first conversion seen
    logic seen_done_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            seen_done_r <= 1'b0;
        end else if (conv_done) begin
            seen_done_r <= 1'b1;
        end
    end

    AST_RESULT_PAD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_03
        q_r.result[3:0] == RESULT_PAD) else $error("result low nibble not zero");

    AST_RESULT_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_02
        !seen_done_r |-> q_r.result == RESULT_RESET) else $error("result set before done");

    AST_RESULT_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_01
        conv_done |=> q_r.result == {$past(adc_code), RESULT_PAD})
        else $error("result not loaded on done");

    AST_RESULT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_16
        !conv_done |=> $stable(q_r.result)) else $error("result changed without done");

    AST_CFG_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_04
        $past(!rst_b) |-> {!conv_active, q_r.cfg} == CONFIG_RESET)
        else $error("configuration reset value wrong");

    AST_START_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_06
        q_r.start |-> !conv_active ##1 conv_active) else $error("start while busy or lost");

    AST_OS_READ: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_07
        conv_active |-> rd_word(PTR_CONFIG, q_r.result, q_r.cfg, busy_now) < 16'h8000)
        else $error("status bit does not track busy");

    AST_CONT_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_10
        (q_r.cfg.single_mode != MODE_SINGLE)[*2] |-> conv_active)
        else $error("continuous mode not converting");

    AST_ALERT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_13
        (q_r.cfg.comparator_queue == QUEUE_OFF)[*2] |-> alert_drive_b)
        else $error("alert driven while disabled");

    AST_ALERT_POL: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_14
        (q_r.cfg.comparator_queue != QUEUE_OFF && q_r.cfg.comparator_polarity)[*2]
        |-> !alert_drive_b && !alert_out) else $error("active high alert not driven low");

endmodule
`default_nettype wire

/* tb/arc_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none

// serial master model, data is open drain with a pull-up on the line
module arc_i2c_master (
    // clock
    input wire logic clk_sys,
    // bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // bus idles released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one clock phase, double the 4 clk minimum for margin
    task automatic ph();
        repeat (8) @(posedge clk_sys);
    endtask
    // start or repeated start, data falls while clock high
    task automatic start();
        sda_low <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b0;
        ph();
    endtask
    // stop, data rises while clock high
    task automatic stop();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b0;
        ph();
    endtask
    // data set while clock low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        ph();
        scl <= 1'b1;
        ph();
        r = sda_line;
        scl <= 1'b0;
        ph();
    endtask
    // byte out msb first, ack is true when the slave pulled low
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // byte in msb first, then our ack or nack
    task automatic rd_byte(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(!ack, r);
    endtask
endmodule

`default_nettype wire

/* tb/adc_result_and_config_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module adc_result_and_config_regs_tb_top;
    import arc_pkg::*;
    localparam int unsigned SIM_HZ = 400_000; // shortens conversions
    localparam logic [6:0] ADDR = 7'h2a; // arbitrary address
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic scl;
    logic sda_low;
    wire logic sda_line;
    logic sda_drive_b;
    arc_cfg_t cfg_out;
    logic conv_active;
    logic conv_done;
    logic alert_drive_b;
    logic sda_pin_out;
    logic alert_out;
    int errors = 0;
    int compares = 0;
    int n_done = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;

    always #12.5 clk_sys = ~clk_sys;
    // wired-and data line, released reads high
    assign sda_line = !(sda_low || !sda_drive_b);

    arc_regs #(.DEV_ADDR(ADDR), .CLK_HZ(SIM_HZ)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl_pin(scl), .sda_pin_in(sda_line),
        .sda_pin_out(sda_pin_out), .sda_drive_b(sda_drive_b), .adc_code(adc_code),
        .cfg_out(cfg_out), .conv_active(conv_active), .conv_done(conv_done),
        .alert_out(alert_out), .alert_drive_b(alert_drive_b));
    arc_i2c_master m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    // count conversions and their spacing in clocks
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (conv_done === 1'b1) begin
            n_done <= n_done + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end
    // pointer write, optionally followed by a data word
    task automatic wr_reg(input logic [1:0] p, input logic [15:0] d, input logic dat);
        logic a0, a1, a2, a3;
        a2 = 1'b1;
        a3 = 1'b1;
        m.start();
        m.wr_byte({ADDR, 1'b0}, a0);
        m.wr_byte({6'h00, p}, a1);
        if (dat) begin
            m.wr_byte(d[15:8], a2);
            m.wr_byte(d[7:0], a3);
        end
        m.stop();
        `CHK({a0, a1, a2, a3}, 4'hf)
    endtask
    // set pointer, read word msb first, compare
    task automatic chk_reg(input logic [1:0] p, input logic [15:0] e);
        logic [15:0] d;
        logic a0;
        wr_reg(p, 16'h0000, 1'b0);
        m.start();
        m.wr_byte({ADDR, 1'b1}, a0);
        m.rd_byte(d[15:8], 1'b1);
        m.rd_byte(d[7:0], 1'b0);
        m.stop();
        `CHK({a0, d}, {1'b1, e})
    endtask
    // bounded wait for a conversion count
    task automatic wait_done(input int n);
        for (int i = 0; i < 5000 && n_done < n; i++) begin
            @(posedge clk_sys);
        end
        `CHK(n_done, n)
    endtask
    // verdict and end of run
    task automatic wrap_up();
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run
    initial begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end

    initial begin
        logic [15:0] d;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        `CHK(cfg_out, CONFIG_RESET[14:0])
        `CHK(alert_drive_b, 1'b1)
        `CHK({sda_pin_out, alert_out}, 2'h0)
        chk_reg(PTR_CONFIG, 16'h8583);
        chk_reg(PTR_RESULT, 16'h0000);
        adc_code <= 12'h8a5;
        wr_reg(PTR_RESULT, 16'hffff, 1'b1);
        chk_reg(PTR_RESULT, 16'h0000);
        chk_reg(PTR_LO_THRESH, 16'h0000);
        // every code of each field except the mode bit, kept single-shot, written while idle with the start bit clear
        for (int i = 0; i < 8; i++) begin
            d = {1'b0, i[2:0], i[2:0], 1'b1, i[2:0], i[0], i[1], i[2], i[1:0]};
            wr_reg(PTR_CONFIG, d, 1'b1);
            `CHK(cfg_out, d[14:0])
            `CHK(alert_drive_b, !(i[1] && i[1:0] != 2'h3))
            chk_reg(PTR_CONFIG, {1'b1, d[14:0]});
        end
        `CHK(n_done, 0)
        // single shot at the slowest rate, second start while busy
        wr_reg(PTR_CONFIG, 16'h8503, 1'b1);
        `CHK(conv_active, 1'b1)
        wr_reg(PTR_CONFIG, 16'h8503, 1'b1);
        chk_reg(PTR_CONFIG, 16'h0503);
        wait_done(1);
        adc_code <= 12'h123;
        chk_reg(PTR_RESULT, 16'h8a50);
        repeat (3200) @(posedge clk_sys);
        `CHK({n_done, conv_active}, {32'd1, 1'b0})
        // continuous at the fastest rate
        wr_reg(PTR_CONFIG, 16'h04c3, 1'b1);
        wait_done(n_done + 3);
        `CHK(gap >= 121 && gap <= 122, 1'b1)
        chk_reg(PTR_RESULT, 16'h1230);
        // back to single shot, conversions stop
        wr_reg(PTR_CONFIG, 16'h05c3, 1'b1);
        repeat (300) @(posedge clk_sys);
        d = n_done[15:0];
        repeat (300) @(posedge clk_sys);
        `CHK(n_done[15:0], d)
        chk_reg(PTR_RESULT, 16'h1230);
        wrap_up();
    end
endmodule

`default_nettype wire
